// ==== dxe_engine.sv ====
// Purpose: external bus side of a multi-channel dma engine
// Assumes: one mclk domain; bus clock output is mclk divided by two
// Notes: read and write lanes run side by side on separate strobes
`timescale 1ns/100ps
`default_nettype none
module dxe_engine (
    // clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // channel control from the cpu side
    input wire logic [dxe_pkg::DXE_CHANNELS-1:0] en_set,
    input wire logic [dxe_pkg::DXE_CHANNELS-1:0] en_clr,
    input wire logic [dxe_pkg::DXE_CHANNELS-1:0] autobuffer_mode,
    input wire logic [dxe_pkg::DXE_CHANNELS-1:0] autoinit_mode,
    input wire logic [dxe_pkg::DXE_CHANNELS-1:0] block_done,
    output logic [dxe_pkg::DXE_CHANNELS-1:0] channel_enable_bit,
    // read request and answer
    input wire logic rd_req,
    input wire dxe_pkg::dxe_loc_t rd_loc,
    output logic rd_busy,
    output logic rd_done,
    output logic [dxe_pkg::DXE_DATA_W-1:0] rd_data,
    // write request and answer
    input wire logic wr_req,
    input wire dxe_pkg::dxe_loc_t wr_loc,
    input wire logic [dxe_pkg::DXE_DATA_W-1:0] wr_wdata,
    output logic wr_busy,
    output logic wr_done,
    // internal page-zero memory write port
    output logic int_we,
    output logic [dxe_pkg::DXE_ADDR_W-1:0] int_addr,
    output logic [dxe_pkg::DXE_DATA_W-1:0] int_wdata,
    // external bus pins
    input wire logic cpu_cycle,
    input wire logic ready,
    input wire logic [dxe_pkg::DXE_DATA_W-1:0] ext_din,
    output logic bus_clock_output,
    output logic dma_cycle,
    output logic ext_rd_strobe,
    output logic ext_wr_strobe,
    output dxe_pkg::dxe_loc_t ext_rd_loc,
    output dxe_pkg::dxe_loc_t ext_wr_loc,
    output logic [dxe_pkg::DXE_DATA_W-1:0] ext_dout
);
    import dxe_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // true when the location is page-zero, low half of data or program
    function automatic logic is_internal(input dxe_loc_t l);
        is_internal = (l.page == DXE_PAGE_ZERO) && (l.space != DXE_SP_IO)
            && !l.addr[DXE_LOW_HALF_BIT];
    endfunction

    // both lanes finish external accesses on one condition: ready seen at a bus clock rise
    // while the processor does not own the bus
    function automatic logic lane_finish(input logic rdy, input logic cpu);
        lane_finish = rdy && !cpu;
    endfunction

    logic ready_s1;
    logic ready_s2;
    logic rise_en;
    logic fall_en;
    logic dma_ready;
    logic cpu_ready;
    dxe_state_t rd_state;
    dxe_state_t wr_state;
    logic wr_int;

    ////////////////////////////////////////////////////////////////////
    // bus clock divider: rise_en marks the rising edge, fall_en falling
    // low after reset, so the first enabled edge is a rise
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            bus_clock_output <= 1'b0;
        end else begin
            bus_clock_output <= ~bus_clock_output;
        end
    end
    assign rise_en = ~bus_clock_output;
    assign fall_en = bus_clock_output;

    // ready is a pin from another domain: two flops before any use
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            ready_s1 <= 1'b0;
            ready_s2 <= 1'b0;
        end else begin
            ready_s1 <= ready;
            ready_s2 <= ready_s1;
        end
    end

    // dma lanes take ready at rising edges, cpu cycles at falling edges
    assign dma_ready = ready_s2 && rise_en; // RULE_08
    assign cpu_ready = ready_s2 && fall_en; // RULE_07
    assign dma_cycle = !cpu_cycle && (rd_busy || wr_busy); // RULE_12

    ////////////////////////////////////////////////////////////////////
    // read lane, independent of the write lane
    assign rd_busy = rd_state != DXE_IDLE; // RULE_04
    assign ext_rd_strobe = rd_state == DXE_WAIT;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rd_state <= DXE_IDLE;
            rd_done <= 1'b0;
            rd_data <= '0;
            ext_rd_loc <= '0;
        end else begin
            rd_done <= 1'b0;
            case (rd_state)
                DXE_IDLE: begin
                    if (rd_req) begin
                        ext_rd_loc <= rd_loc; // RULE_01
                        rd_state <= DXE_ADDR;
                    end
                end
                DXE_ADDR: begin
                    // address settles half or one whole bus clock before the strobe
                    if (rise_en) begin
                        rd_state <= DXE_WAIT;
                    end
                end
                DXE_WAIT: begin
                    // stay while device not ready; data and done share
                    // one edge, so done never runs ahead of the data
                    if (lane_finish(dma_ready, cpu_cycle)) begin // RULE_06
                        rd_data <= ext_din;
                        rd_done <= 1'b1; // RULE_05
                        rd_state <= DXE_IDLE;
                    end
                end
                default: rd_state <= DXE_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // write lane; page-zero internal words are written only for page 0
    assign wr_busy = wr_state != DXE_IDLE; // RULE_04
    assign ext_wr_strobe = (wr_state == DXE_WAIT) && !wr_int;

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wr_state <= DXE_IDLE;
            wr_done <= 1'b0;
            wr_int <= 1'b0;
            ext_wr_loc <= '0;
            ext_dout <= '0;
        end else begin
            wr_done <= 1'b0;
            case (wr_state)
                DXE_IDLE: begin
                    if (wr_req) begin
                        ext_wr_loc <= wr_loc; // RULE_01
                        ext_dout <= wr_wdata;
                        wr_int <= is_internal(wr_loc); // RULE_02
                        wr_state <= DXE_ADDR;
                    end
                end
                DXE_ADDR: begin
                    // an internal word never drives the bus, so no wait
                    if (wr_int) begin
                        wr_done <= 1'b1;
                        wr_state <= DXE_IDLE;
                    end else if (rise_en) begin
                        wr_state <= DXE_WAIT;
                    end
                end
                DXE_WAIT: begin
                    if (lane_finish(dma_ready, cpu_cycle)) begin // RULE_06
                        wr_done <= 1'b1;
                        wr_state <= DXE_IDLE;
                    end
                end
                default: wr_state <= DXE_IDLE;
            endcase
        end
    end

    // extended pages never reach the internal array
    assign int_we = (wr_state == DXE_ADDR) && wr_int; // RULE_02
    assign int_addr = ext_wr_loc.addr;
    assign int_wdata = ext_dout;

    ////////////////////////////////////////////////////////////////////
    // enables: set wins over hardware clear so no request is lost
    logic [DXE_CHANNELS-1:0] hw_clear;
    logic [DXE_CHANNELS-1:0] next_channel_enable_bit;

    // only one-shot channels lose their enable when the block ends
    assign hw_clear = block_done // RULE_10
        & ~(autobuffer_mode | autoinit_mode);

    always_comb begin
        next_channel_enable_bit = channel_enable_bit & ~en_clr & ~hw_clear;
        // auto channels keep the bit until software clears it
        next_channel_enable_bit = next_channel_enable_bit | en_set; // RULE_11
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            channel_enable_bit <= DXE_ENABLE_RESET;
        end else begin
            channel_enable_bit <= next_channel_enable_bit;
        end
    end

    // cpu_ready stays internal; no port passes it to processor-owned wait logic
    // limitation: no processor wait logic lives here, so this flag only
    // marks the falling-edge sample that such logic would take
    logic cpu_ready_seen;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cpu_ready_seen <= 1'b0;
        end else begin
            cpu_ready_seen <= cpu_ready && cpu_cycle;
        end
    end
endmodule
`default_nettype wire

// ==== dxe_engine_tb.sv ====
// Purpose: self-checking bench for dxe_engine
// Assumes: 10 MHz mclk, inputs driven on the falling edge
// Notes: lfsr stimulus seeded at 5
`timescale 1ns/100ps
`default_nettype none
module dxe_engine_tb;
    import dxe_pkg::*;
    logic mclk = 1'h0, rstn = 1'h0, rd_req = 1'h0, wr_req = 1'h0;
    logic cpu_cycle = 1'h0;
    logic [5:0] en_set = 6'h00, en_clr = 6'h00, block_done = 6'h00;
    logic [5:0] autobuffer_mode = 6'h00, autoinit_mode = 6'h00;
    logic [5:0] channel_enable_bit;
    logic rd_busy, rd_done, wr_busy, wr_done, int_we, ready, dma_cycle;
    logic ext_rd_strobe, ext_wr_strobe, bus_clock_output;
    logic [15:0] rd_data, int_addr, int_wdata, ext_din, ext_dout, cap;
    logic [15:0] wr_wdata = 16'h0000, r = 16'h0005, q = 16'h0005;
    logic [3:0] slow = 4'h0;
    dxe_loc_t rd_loc = 25'h0000000, wr_loc = 25'h0000000, ext_rd_loc, ext_wr_loc;
    int n_errors = 0, compares = 0, n_int = 0;
    always #50 mclk = ~mclk;
    dxe_engine dxe_engine_i (.mclk, .rstn, .en_set, .en_clr, .autobuffer_mode,
        .autoinit_mode, .block_done, .channel_enable_bit, .rd_req, .rd_loc,
        .rd_busy, .rd_done, .rd_data, .wr_req, .wr_loc, .wr_wdata, .wr_busy,
        .wr_done, .int_we, .int_addr, .int_wdata, .cpu_cycle, .ready, .ext_din,
        .bus_clock_output, .dma_cycle, .ext_rd_strobe, .ext_wr_strobe,
        .ext_rd_loc, .ext_wr_loc, .ext_dout);
    dxe_mem_model dxe_mem_model_i (.mclk, .rstn, .ext_rd_strobe, .ext_wr_strobe,
        .ext_rd_loc, .slow, .ready, .ext_din);
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    // folding the address into the word checks where it went too
    // sampled mid-cycle, where the strobes have settled
    always @(negedge mclk) begin
        if (int_we) n_int++;
        if (int_we) cap = int_wdata ^ int_addr;
        if (ext_wr_strobe) cap = ext_dout ^ ext_wr_loc.addr;
    end
    always @(negedge mclk) begin
        q = lfsr(q);
        cpu_cycle = rstn & (q[2:0] == 3'h0);
    end
    task automatic chk(input string s, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic rd(input dxe_loc_t l);
        @(negedge mclk);
        rd_loc = l;
        rd_req = 1'h1;
        @(negedge mclk);
        rd_req = 1'h0;
        for (int k = 0; k < 300 && rd_done !== 1'h1; k++) @(negedge mclk);
        chk("rd_done", 16'h0001, {15'h0000, rd_done});
        chk("rd_data", l.addr ^ {9'h000, l.page}, rd_data);
    endtask
    task automatic wr(input dxe_loc_t l, input logic [15:0] d);
        int n0;
        n0 = n_int;
        @(negedge mclk);
        wr_loc = l;
        wr_wdata = d;
        wr_req = 1'h1;
        @(negedge mclk);
        wr_req = 1'h0;
        for (int k = 0; k < 300 && wr_done !== 1'h1; k++) @(negedge mclk);
        chk("wr_word", d ^ l.addr, cap);
        chk("int_we", {15'h0000, l.page == DXE_PAGE_ZERO && !l.addr[15] &&
            l.space != DXE_SP_IO}, 16'(n_int - n0));
    endtask
    task automatic results;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #3000000;
        n_errors++;
        results;
    end
    initial begin
        repeat (20) @(negedge mclk);
        rstn = 1'h1;
        for (int i = 0; i < 16; i++) begin
            r = lfsr(r);
            slow = r[3:0];
            fork
                rd({r[15:9], lfsr(r), 2'(r % 3)});
                wr({i[0] ? r[6:0] : 7'h00, ~r, 2'(i % 3)}, lfsr(~r));
            join
        end
        $display("test concurrent traffic done");
        wr({7'h7f, 16'h7fff, DXE_SP_DATA}, r);
        wr({7'h00, 16'h0000, DXE_SP_PROG}, ~r);
        $display("test page corners done");
        en_set = 6'h3f;
        @(negedge mclk);
        en_set = 6'h00;
        autobuffer_mode = r[5:0];
        autoinit_mode = r[13:8];
        block_done = 6'h3f;
        @(negedge mclk);
        block_done = 6'h00;
        chk("enable", {10'h000, r[5:0] | r[13:8]},
            {10'h000, channel_enable_bit});
        en_clr = 6'h3f;
        @(negedge mclk);
        en_clr = 6'h00;
        chk("enable", 16'h0000, {10'h000, channel_enable_bit});
        $display("test channel enables done");
        en_set = 6'h3f;
        @(negedge mclk);
        en_set = 6'h00;
        rstn = 1'h0;
        @(negedge mclk);
        chk("rst enable", 16'h0000, {10'h000, channel_enable_bit});
        chk("rst clock", 16'h0000, {15'h0000, bus_clock_output});
        rstn = 1'h1;
        rd({7'h01, 16'h8001, DXE_SP_IO});
        $display("test mid-run reset done");
        results;
    end
endmodule
`default_nettype wire

// ==== dxe_mem_model.sv ====
// Purpose: external memory and io devices on the far bus side
// Assumes: ready high means the device can finish
// Notes: read data is a function of the location
`timescale 1ns/100ps
`default_nettype none
module dxe_mem_model (
    // bus from the engine
    input wire logic mclk, rstn, ext_rd_strobe, ext_wr_strobe,
    input wire dxe_pkg::dxe_loc_t ext_rd_loc,
    // wait states asked by the bench
    input wire logic [3:0] slow,
    output logic ready,
    output logic [15:0] ext_din
);
    import dxe_pkg::*;
    logic [3:0] cnt;
    // ready moves on every mclk rising edge, at bus clock rises and falls alike
    always_ff @(posedge mclk or negedge rstn)
        if (!rstn) cnt <= 4'h0;
        else if (!(ext_rd_strobe || ext_wr_strobe)) cnt <= 4'h0;
        else if (cnt != 4'hf) cnt <= cnt + 4'h1;
    assign ready = cnt >= slow;
    // off the strobe the bus shows the inverse, never a stale word
    assign ext_din = (ext_rd_loc.addr ^ {9'h000, ext_rd_loc.page})
        ^ {16{!ext_rd_strobe}};
endmodule
`default_nettype wire

// ==== dxe_pkg.sv ====
// Purpose: shared constants and types for the dma external access engine
// Assumes: 10 MHz mclk, 16-bit words, 7-bit page numbers
// Notes: the bus clock output runs at half mclk, made by a divider enable
//
// Notes on behaviour
// [RULE_01] Addresses reach 128 pages in data, I/O and program spaces.
// [RULE_02] Extended page low 32K writes go external only, never internal.
// [RULE_03] Software on faulty parts avoids low 32K of pages 1 to 127.
// [RULE_04] One external read and one external write may run together.
// [RULE_05] Read done is reported only after data is really captured.
// [RULE_06] External accesses stretch while ready says not ready.
// [RULE_07] Processor cycles sample ready on the bus clock falling edge.
// [RULE_08] DMA cycles sample ready on the bus clock rising edge.
// [RULE_09] External logic times ready per cycle owner, or uses soft waits.
// [RULE_10] Block done clears channel enable unless autobuffer or autoinit.
// [RULE_11] Autobuffer or autoinit channels stay enabled until software clears.
// [RULE_12] An output tells whether the current bus cycle is DMA or processor.
package dxe_pkg;
    localparam int DXE_CHANNELS = 6;
    localparam int DXE_PAGE_W = 7;
    localparam int DXE_ADDR_W = 16;
    localparam int DXE_DATA_W = 16;
    localparam logic [DXE_PAGE_W-1:0] DXE_PAGE_ZERO = 7'h00;
    localparam int DXE_LOW_HALF_BIT = 15;
    localparam logic [DXE_CHANNELS-1:0] DXE_ENABLE_RESET = 6'h00;

    typedef enum logic [1:0] {
        DXE_SP_DATA = 2'h0,
        DXE_SP_IO = 2'h1,
        DXE_SP_PROG = 2'h2
    } dxe_space_t;

    typedef struct packed {
        logic [DXE_PAGE_W-1:0] page;
        logic [DXE_ADDR_W-1:0] addr;
        dxe_space_t space;
    } dxe_loc_t;

    typedef enum logic [1:0] {
        DXE_IDLE = 2'h0,
        DXE_ADDR = 2'h1,
        DXE_WAIT = 2'h2
    } dxe_state_t;
endpackage

// ==== dxe_props.sv ====
// Purpose: port assertions for dxe_engine
// Assumes: one mclk domain
// Notes: attached by the bind at the foot
`timescale 1ns/100ps
`default_nettype none
module dxe_props (
    // watched ports
    input wire logic mclk, rstn, rd_req, rd_busy, rd_done, cpu_cycle,
    input wire logic ready, int_we, dma_cycle, bus_clock_output,
    input wire logic ext_rd_strobe, ext_wr_strobe,
    input wire logic [5:0] en_set, en_clr, autobuffer_mode,
    input wire logic [5:0] autoinit_mode, block_done, channel_enable_bit,
    input wire dxe_pkg::dxe_loc_t ext_wr_loc
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    // the first edge after reset has no earlier bus clock value to compare
    a_bus_clk_half: assert property ($past(rstn)
        |-> bus_clock_output != $past(bus_clock_output))
        else $error("bus clock not toggling");
    a_rd_take: assert property (rd_req && !rd_busy |=> rd_busy)
        else $error("read not taken");
    a_rd_done_pulse: assert property (rd_done |=> !rd_done)
        else $error("read done too long");
    a_rd_after_access: assert property (rd_done
        |-> $past(ext_rd_strobe)) else $error("read done without access");
    // six low samples cover the two-flop sync and the rise wait
    a_ready_stall: assert property (!ready [*6] |-> !rd_done)
        else $error("read ended while not ready");
    a_ext_not_int: assert property (int_we
        |-> ext_wr_loc.page == 7'h00 && !ext_wr_loc.addr[15]
        && ext_wr_loc.space != dxe_pkg::DXE_SP_IO)
        else $error("internal write from extended page");
    a_cpu_owns: assert property (cpu_cycle |-> !dma_cycle)
        else $error("dma flag during cpu cycle");
    a_dma_flag: assert property ((ext_rd_strobe || ext_wr_strobe)
        && !cpu_cycle |-> dma_cycle) else $error("dma flag missing");
    // the read lane holds while the processor owns the bus
    a_cpu_hold: assert property (cpu_cycle |=> !rd_done)
        else $error("read finished in a cpu cycle");
    a_en_clear: assert property ((channel_enable_bit &
        $past(block_done & ~autobuffer_mode & ~autoinit_mode & ~en_set))
        == 6'h00) else $error("enable kept after block");
    a_en_keep: assert property (($past(channel_enable_bit &
        (autobuffer_mode | autoinit_mode) & ~en_clr) & ~channel_enable_bit)
        == 6'h00) else $error("auto channel lost enable");
    c_both: cover property (ext_rd_strobe && ext_wr_strobe);
    c_int: cover property (int_we);
    c_keep: cover property (|(block_done & autobuffer_mode));
endmodule
bind dxe_engine dxe_props dxe_props_i (.mclk, .rstn, .rd_req, .rd_busy,
    .rd_done, .cpu_cycle, .ready, .int_we, .dma_cycle, .bus_clock_output,
    .ext_rd_strobe, .ext_wr_strobe, .en_set, .en_clr, .autobuffer_mode,
    .autoinit_mode, .block_done, .channel_enable_bit, .ext_wr_loc);
`default_nettype wire
